// ### design/dual_pointer_params.svh
`ifndef DUAL_POINTER_PARAMS_SVH
`define DUAL_POINTER_PARAMS_SVH

// APB byte addresses
`define ADDR_POINTER_CONTROL 12'h000
`define ADDR_POINTER_LOW 12'h004
`define ADDR_POINTER_HIGH 12'h008
`define ADDR_POINTER_PAGE 12'h00C
`define ADDR_MAIN_POINTER 12'h010
`define ADDR_SHADOW_POINTER 12'h014
`define ADDR_MOVE_COUNT 12'h018

// Field positions of the control byte
`define BIT_RESERVED 7
`define BIT_AUTO_TOGGLE 6
`define BIT_SHADOW_MODE_HIGH 5
`define BIT_SHADOW_MODE_LOW 4
`define BIT_MAIN_MODE_HIGH 3
`define BIT_MAIN_MODE_LOW 2
`define BIT_UNUSED 1
`define BIT_POINTER_SELECT 0

// Reset values
`define CONTROL_RESET 8'h00
`define POINTER_RESET 24'h000000

// Mask of storage bits in the control byte
`define CONTROL_STORE_MASK 8'h7D

`endif

// ### design/dual_pointer_pkg.sv
package dual_pointer_pkg;

  // Post-operation of one pointer
  typedef enum logic [1:0]
  {
    POST_NONE = 2'h0,
    POST_INC = 2'h1,
    POST_DEC = 2'h2,
    POST_LSB = 2'h3
  } post_op_type;

  // Kind of move reported by the core
  typedef enum logic [1:0]
  {
    MOVE_NONE,
    MOVE_POINTER,
    MOVE_PC_RELATIVE,
    MOVE_REG_INDIRECT
  } move_kind_type;

  // Stored control fields
  typedef struct packed
  {
    logic auto_toggle_enable;
    post_op_type shadow_mode;
    post_op_type main_mode;
    logic pointer_select;
  } control_type;

  // Move request from the core
  typedef struct packed
  {
    logic valid;
    move_kind_type kind;
    logic is_code;
  } move_req_type;

endpackage

// ### design/pointer_post_op.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Post-operation of one 24-bit pointer
// ---------------------------------------------------------------
module pointer_post_op
  import dual_pointer_pkg::*;
(
  input wire logic [23:0] value, // Current pointer value
  input wire post_op_type mode, // Chosen post-operation
  input wire logic apply, // Apply the operation
  output logic [23:0] result // Value after the move
);

  // Select the new value
  always_comb
  begin
    result = value;
    if (apply)
    begin
      case (mode)
        POST_INC: result = value + 24'h000001; // Wraps modulo 2^24
        POST_DEC: result = value - 24'h000001; // Wraps modulo 2^24
        POST_LSB: result = {value[23:1], ~value[0]}; // Bit 0 only
        default: result = value; // No operation
      endcase
    end
  end

endmodule

// ### design/pointer_apb_decode.sv
`timescale 1ns/1ps
`include "dual_pointer_params.svh"
// ---------------------------------------------------------------
// APB address decode for the pointer registers
// ---------------------------------------------------------------
module pointer_apb_decode
(
  input wire logic [11:0] paddr, // Byte address
  output logic [2:0] index, // Register index
  output logic hit // Address is mapped
);

  // Map address to register index
  always_comb
  begin
    hit = 1'b1;
    case (paddr)
      `ADDR_POINTER_CONTROL: index = 3'h0;
      `ADDR_POINTER_LOW: index = 3'h1;
      `ADDR_POINTER_HIGH: index = 3'h2;
      `ADDR_POINTER_PAGE: index = 3'h3;
      `ADDR_MAIN_POINTER: index = 3'h4;
      `ADDR_SHADOW_POINTER: index = 3'h5;
      `ADDR_MOVE_COUNT: index = 3'h6;
      default:
      begin
        index = 3'h7; // Unmapped
        hit = 1'b0;
      end
    endcase
  end

endmodule

// ### design/dual_data_pointer_control.sv
`timescale 1ns/1ps
`include "dual_pointer_params.svh"
// Notes on behaviour
// - Auto-toggle bit flips select after each pointer-addressed move
// - Shadow mode: none, increment, decrement, LSB
// - Main mode: none, increment, decrement, LSB
// - Bit 1 unstored; increment only flips select
// - Select picks main or shadow pointer bytes
// - Only pointer-addressed moves trigger post-operations
// - Post-operation first, then automatic swap
// - Active pointer used; inactive one holds
// - Bit 7 reserved, reads zero
// - Control register clears to zero at reset
module dual_data_pointer_control
  import dual_pointer_pkg::*;
(
  input wire logic pclk, // Core clock, 100 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire move_req_type move_req, // Move report from the core
  input wire logic control_inc, // Core increments the control byte
  output logic [23:0] active_pointer, // Selected pointer value
  output logic pointer_select // Current select bit
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  control_type control; // Stored control fields
  control_type next_control;
  logic [23:0] main_pointer; // Main pointer
  logic [23:0] next_main_pointer;
  logic [23:0] shadow_pointer; // Shadow pointer
  logic [23:0] next_shadow_pointer;
  logic [15:0] move_count; // Count of qualifying moves
  logic [15:0] next_move_count;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [23:0] next_active_pointer;

  // Reset value of the stored fields, unpacked from the control byte
  // field by field, since bit 1 has no place in the stored struct
  localparam logic [7:0] CONTROL_BYTE_INIT = `CONTROL_RESET;
  localparam control_type CONTROL_INIT = '{
    auto_toggle_enable: CONTROL_BYTE_INIT[`BIT_AUTO_TOGGLE],
    shadow_mode: post_op_type'(
      CONTROL_BYTE_INIT[`BIT_SHADOW_MODE_HIGH:`BIT_SHADOW_MODE_LOW]),
    main_mode: post_op_type'(
      CONTROL_BYTE_INIT[`BIT_MAIN_MODE_HIGH:`BIT_MAIN_MODE_LOW]),
    pointer_select: CONTROL_BYTE_INIT[`BIT_POINTER_SELECT]
  };

  // ---------------------------------------------------------------
  // Bus decode and move qualification
  // ---------------------------------------------------------------
  logic [2:0] reg_index; // Decoded register
  logic reg_hit; // Address is mapped
  logic bus_write; // Write takes effect this edge
  logic bus_read; // Read data taken this edge
  logic qualify; // Move that uses the pointer
  logic [23:0] main_after; // Main pointer after its post-op
  logic [23:0] shadow_after; // Shadow pointer after its post-op
  logic [7:0] control_byte; // Control as software sees it
  logic [23:0] selected; // Currently selected pointer

  pointer_apb_decode u_decode
  (
    .paddr(paddr),
    .index(reg_index),
    .hit(reg_hit)
  );

  // Access phase completes in two cycles, with one wait state
  // The master keeps the access phase up through the ready cycle,
  // so the pready gate stops a second write or a second read
  // sample of the same transfer
  assign bus_write = psel && penable && pwrite && !pready;
  assign bus_read = psel && penable && !pwrite && !pready;

  // Only pointer-addressed code reads or data moves count
  // Program-counter-relative reads and register-indirect moves
  // never qualify; whether the move was a code read or a data
  // move makes no difference to the post-operation
  assign qualify = move_req.valid &&
    (move_req.kind == MOVE_POINTER);

  // Control byte: bit 7 and bit 1 read zero
  // Neither bit has a flip-flop, so a write to them is lost
  assign control_byte = {1'b0, control.auto_toggle_enable,
    control.shadow_mode, control.main_mode, 1'b0,
    control.pointer_select};

  // Select main when 0, shadow when 1
  assign selected = control.pointer_select ? shadow_pointer :
    main_pointer;

  // ---------------------------------------------------------------
  // Post-operation units
  // ---------------------------------------------------------------
  // Each unit is gated by the select bit, so the inactive pointer
  // passes through unchanged whatever its mode field says

  // Post-operation of main pointer only while it is active
  pointer_post_op u_main_op
  (
    .value(main_pointer),
    .mode(control.main_mode),
    .apply(qualify && !control.pointer_select),
    .result(main_after)
  );

  // Post-operation of shadow pointer only while it is active
  pointer_post_op u_shadow_op
  (
    .value(shadow_pointer),
    .mode(control.shadow_mode),
    .apply(qualify && control.pointer_select),
    .result(shadow_after)
  );

  // ---------------------------------------------------------------
  // Next-state logic for control and pointers
  // ---------------------------------------------------------------
  // Priority, lowest first: post-operation of the active pointer,
  // automatic swap, core increment of the control byte, and last
  // a software write, which replaces what the core asked for in the
  // register it writes, in the same edge
  always_comb
  begin
    logic [23:0] write_value;
    write_value = selected;
    next_control = control;
    next_main_pointer = main_after;
    next_shadow_pointer = shadow_after;
    next_move_count = move_count;
    // Post-op applied above; swap follows it
    if (qualify)
    begin
      next_move_count = move_count + 16'h0001;
      if (control.auto_toggle_enable)
      begin
        next_control.pointer_select = ~control.pointer_select;
      end
    end
    // Increment of control: carry stops at bit 0
    // A swap and an increment in one edge flip the select bit
    // only once, as both write the same inverted value
    if (control_inc)
    begin
      next_control.pointer_select = ~control.pointer_select;
    end
    // Software writes win over core events
    if (bus_write)
    begin
      case (reg_index)
        // Control byte; bits 7 and 1 are dropped
        3'h0:
        begin
          if (pstrb[0])
          begin
            next_control.auto_toggle_enable =
              pwdata[`BIT_AUTO_TOGGLE];
            next_control.shadow_mode = post_op_type'(
              pwdata[`BIT_SHADOW_MODE_HIGH:`BIT_SHADOW_MODE_LOW]);
            next_control.main_mode = post_op_type'(
              pwdata[`BIT_MAIN_MODE_HIGH:`BIT_MAIN_MODE_LOW]);
            next_control.pointer_select =
              pwdata[`BIT_POINTER_SELECT];
          end
        end
        // Low byte of the active pointer
        3'h1:
        begin
          if (pstrb[0])
          begin
            write_value[7:0] = pwdata[7:0];
          end
        end
        // High byte of the active pointer
        3'h2:
        begin
          if (pstrb[0])
          begin
            write_value[15:8] = pwdata[7:0];
          end
        end
        // Page byte of the active pointer
        3'h3:
        begin
          if (pstrb[0])
          begin
            write_value[23:16] = pwdata[7:0];
          end
        end
        default:
        begin
          write_value = selected; // Read-only or unmapped
        end
      endcase
      // Byte writes reach the active pointer only
      // The written byte is merged into the old pointer value
      if (reg_index >= 3'h1 && reg_index <= 3'h3)
      begin
        if (control.pointer_select)
        begin
          next_shadow_pointer = write_value;
        end
        else
        begin
          next_main_pointer = write_value;
        end
      end
    end
  end

  // Register control and pointers
  // Reset loads constants only; a low clock enable holds every
  // register, as if the clock had stopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control <= CONTROL_INIT;
      main_pointer <= `POINTER_RESET;
      shadow_pointer <= `POINTER_RESET;
      move_count <= 16'h0000;
    end
    else if (clk_en)
    begin
      control <= next_control;
      main_pointer <= next_main_pointer;
      shadow_pointer <= next_shadow_pointer;
      move_count <= next_move_count;
    end
  end

  // ---------------------------------------------------------------
  // APB answer and outputs
  // ---------------------------------------------------------------
  // One wait state on every access: pready rises in the cycle after
  // the access edge and falls again one cycle later; read data
  // stays until the next read, so a slow master still finds it
  always_comb
  begin
    next_pready = bus_write || bus_read;
    next_pslverr = (bus_write || bus_read) && !reg_hit;
    next_prdata = prdata;
    if (bus_read)
    begin
      // Byte registers show the active pointer; main, shadow and count are read only
      case (reg_index)
        3'h0: next_prdata = {24'h000000, control_byte};
        3'h1: next_prdata = {24'h000000, selected[7:0]};
        3'h2: next_prdata = {24'h000000, selected[15:8]};
        3'h3: next_prdata = {24'h000000, selected[23:16]};
        3'h4: next_prdata = {8'h00, main_pointer};
        3'h5: next_prdata = {8'h00, shadow_pointer};
        3'h6: next_prdata = {16'h0000, move_count};
        default: next_prdata = 32'h00000000;
      endcase
    end
    // Outputs follow the state after this edge
    next_active_pointer = next_control.pointer_select ?
      next_shadow_pointer : next_main_pointer;
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  // Register bus answer and outputs
  // The outputs register the next state rather than the state, so
  // they change at the same edge as the pointers and never lag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      active_pointer <= `POINTER_RESET;
      pointer_select <= 1'b0;
    end
    else if (clk_en)
    begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      active_pointer <= next_active_pointer;
      pointer_select <= next_control.pointer_select;
    end
  end

endmodule

// ### tb/pointer_ctrl_sva.sv
`timescale 1ns/1ps
// ---
// Port checker
// ---
module pointer_ctrl_sva
  import dual_pointer_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic clk_en, // Run
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Write
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire move_req_type move_req, // Move
  input wire logic control_inc, // Bump
  input wire logic [23:0] active_pointer, // Active
  input wire logic pointer_select // Select bit
);
  logic qual; // Pointer move
  logic acc; // Access edge
  logic cause; // Any cause
  assign qual = move_req.valid && move_req.kind == MOVE_POINTER;
  assign acc = psel && penable && !pready && clk_en;
  assign cause = qual || control_inc || psel || !clk_en;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_after_access_a: assert property (acc |=> pready)
    else $error("ready late");
  ready_pulse_a: assert property (pready && clk_en |=> !pready)
    else $error("ready held");
  error_unmapped_a: assert property (
    acc && paddr > 12'h018 |=> pready && pslverr)
    else $error("no error on unmapped");
  mapped_ok_a: assert property (
    acc && paddr <= 12'h018 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("error on mapped");
  reserved_zero_a: assert property (
    pready && $past(acc && !pwrite && paddr == 12'h000)
    |-> prdata[7] == 1'b0 && prdata[1] == 1'b0)
    else $error("reserved bit reads one");
  idle_hold_a: assert property (!cause |=>
    $stable(active_pointer) && $stable(pointer_select))
    else $error("state moved without cause");
  bump_flip_a: assert property (
    control_inc && !qual && !psel && clk_en
    |=> pointer_select != $past(pointer_select))
    else $error("bump missed");
  select_cause_a: assert property ($changed(pointer_select)
    |-> $past(qual || control_inc || psel && penable && pwrite))
    else $error("select changed alone");
  reset_clear_a: assert property ($rose(presetn)
    |-> active_pointer == 24'h000000 && !pointer_select)
    else $error("not cleared");
  freeze_hold_a: assert property (!clk_en |=>
    $stable(active_pointer) && $stable(pointer_select) && $stable(pready))
    else $error("state moved while frozen");
  cover property (qual && pointer_select);
  cover property (control_inc);
  cover property (pready && pslverr);
  cover property (!clk_en && qual);
endmodule

bind dual_data_pointer_control pointer_ctrl_sva chk
(
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .move_req(move_req), .control_inc(control_inc),
  .active_pointer(active_pointer), .pointer_select(pointer_select)
);

// ### tb/core_move_model.sv
`timescale 1ns/1ps
// ---
// Core model: move reports and bumps
// ---
module core_move_model
  import dual_pointer_pkg::*;
(
  input wire logic pclk, // Clock
  output move_req_type move_req, // Move report
  output logic control_inc // Bump pulse
);
  // Idle from time zero
  initial
  begin
    move_req = '0;
    control_inc = 1'b0;
  end
  // One-cycle move, then an idle edge
  task automatic move(input move_kind_type k);
    move_req <= '{valid: 1'b1, kind: k, is_code: 1'b0};
    @(posedge pclk);
    move_req <= '0;
    @(posedge pclk);
  endtask
  // One-cycle control bump
  task automatic bump();
    control_inc <= 1'b1;
    @(posedge pclk);
    control_inc <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// ### tb/dual_data_pointer_control_tb_top.sv
`timescale 1ns/1ps
module dual_data_pointer_control_tb_top
  import dual_pointer_pkg::*;
  ;
  logic pclk, presetn, clk_en, psel, penable, pwrite; // Bus side
  logic [11:0] paddr; // Address
  logic [31:0] pwdata, prdata, r; // Data
  logic [3:0] pstrb; // Strobes, all set except in t_refuse
  logic pready, pslverr, control_inc, pointer_select, e; // Flags
  move_req_type move_req; // Core move
  logic [23:0] active_pointer; // Active value
  int num_errors, checks; // Counters

  dual_data_pointer_control dut
  (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .move_req(move_req),
    .control_inc(control_inc), .active_pointer(active_pointer),
    .pointer_select(pointer_select)
  );
  core_move_model core
  (
    .pclk(pclk), .move_req(move_req), .control_inc(control_inc)
  );

  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict
  task automatic close_out();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One APB transfer, entered just after an edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    check(32'(pready), 32'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(r, x);
  endtask
  task automatic set_ptr(input logic [23:0] v);
    apb(1'b1, 12'h004, 32'(v[7:0]));
    apb(1'b1, 12'h008, 32'(v[15:8]));
    apb(1'b1, 12'h00C, 32'(v[23:16]));
  endtask
  // Expected value after one post-operation
  function automatic logic [23:0] post(input int m, input logic [23:0] v);
    case (m)
      1: return v + 24'h000001;
      2: return v - 24'h000001;
      3: return v ^ 24'h000001;
      default: return v;
    endcase
  endfunction
  // Reset values of every register
  task automatic t_reset();
    for (int a = 0; a < 7; a++)
      rd(12'(a * 4), 32'h0);
  endtask
  // Bytes follow the select bit
  task automatic t_select();
    set_ptr(24'h332211);
    check(32'(active_pointer), 32'h332211);
    apb(1'b1, 12'h000, 32'h01);
    check(32'(active_pointer), 32'h0);
    set_ptr(24'h0000AA);
    rd(12'h010, 32'h332211);
    rd(12'h004, 32'hAA);
    apb(1'b1, 12'h000, 32'h00);
    rd(12'h008, 32'h22);
  endtask
  // Every mode of both pointers, at the wrap edges
  task automatic t_modes();
    logic [23:0] st;
    for (int s = 0; s < 2; s++)
      for (int m = 0; m < 4; m++)
      begin
        st = (m == 2) ? 24'h000000 : 24'hFFFFFF;
        apb(1'b1, 12'h000, s ? 32'(m * 16 + 1) : 32'(m * 4));
        set_ptr(st);
        core.move(MOVE_POINTER);
        check(32'(active_pointer), 32'(post(m, st)));
        rd(s ? 12'h014 : 12'h010, 32'(post(m, st)));
        check(32'(pointer_select), 32'(s));
      end
  endtask
  // Post-operation then swap, as in a block copy
  task automatic t_toggle();
    apb(1'b1, 12'h000, 32'h01);
    set_ptr(24'h00D000);
    apb(1'b1, 12'h000, 32'h00);
    set_ptr(24'h000000);
    apb(1'b1, 12'h000, 32'h55);
    core.move(MOVE_POINTER);
    check(32'(pointer_select), 32'h0);
    check(32'(active_pointer), 32'h0);
    rd(12'h014, 32'hD001);
    core.move(MOVE_POINTER);
    check(32'(active_pointer), 32'hD001);
    rd(12'h010, 32'h1);
  endtask
  // Other move kinds leave everything alone
  task automatic t_ignore();
    move_kind_type ks[3];
    ks = '{MOVE_NONE, MOVE_PC_RELATIVE, MOVE_REG_INDIRECT};
    foreach (ks[i])
    begin
      core.move(ks[i]);
      check(32'(active_pointer), 32'hD001);
      check(32'(pointer_select), 32'h1);
    end
    rd(12'h018, 32'h000A);
  endtask
  // Unstored bits and the control bump
  task automatic t_bump();
    apb(1'b1, 12'h000, 32'hFE);
    rd(12'h000, 32'h7C);
    core.bump();
    rd(12'h000, 32'h7D);
    core.bump();
    rd(12'h000, 32'h7C);
  endtask
  // Low clock enable ignores a move and a bump
  task automatic t_freeze();
    clk_en <= 1'b0;
    core.move(MOVE_POINTER);
    core.bump();
    check(32'(active_pointer), 32'h1);
    check(32'(pointer_select), 32'h0);
    clk_en <= 1'b1;
    rd(12'h018, 32'h000A);
  endtask
  // Unmapped, read-only and strobed-off places
  task automatic t_refuse();
    apb(1'b1, 12'h01C, 32'h01);
    check(32'(e), 32'h1);
    apb(1'b1, 12'h010, 32'hFF);
    pstrb <= 4'hE;
    apb(1'b1, 12'h004, 32'h55);
    apb(1'b1, 12'h000, 32'hFF);
    pstrb <= 4'hF;
    rd(12'h004, 32'h01);
    rd(12'h000, 32'h7C);
    rd(12'h010, 32'h1);
    rd(12'h01C, 32'h0);
  endtask
  // Reset in mid-run clears pointers and control
  task automatic t_rerun();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check(32'(active_pointer), 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
  endtask
  // Watchdog
  initial
  begin
    #50000;
    num_errors++;
    close_out();
  end
  // Main sequence
  initial
  begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    num_errors = 0;
    checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_select();
    t_modes();
    t_toggle();
    t_ignore();
    t_bump();
    t_freeze();
    t_refuse();
    t_rerun();
    close_out();
  end
endmodule
